// ==== include/rct_defines.svh ====
// Timing counts and fixed values for the reload/capture timer
`ifndef RCT_DEFINES_SVH
`define RCT_DEFINES_SVH
`define RCT_COUNT_W      16
`define RCT_DIV12        4'hc
`define RCT_TOP_VALUE    16'hffff
`define RCT_CAP_RELOAD   16'h0000
`define RCT_RESET_VALUE  16'h0000
`endif

// ==== include/rct_pkg.sv ====
// Types shared by the reload/capture timer modules
package rct_pkg;
    typedef enum logic {
        RCT_MODE_RELOAD,
        RCT_MODE_CAPTURE
    } rct_mode_t;
    typedef enum logic [1:0] {
        RCT_EDGE_FALL,
        RCT_EDGE_RISE
    } rct_edge_t;
endpackage : rct_pkg

// ==== include/rct_tick_if.sv ====
// Carries the count-enable tick from the prescaler to the timer core
`timescale 1ns/100ps
interface rct_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface : rct_tick_if

// ==== core/rct_prescaler.sv ====
// Divide-by-N count enable for the timer
`timescale 1ns/100ps
`include "rct_defines.svh"
module rct_prescaler import rct_pkg::*; #(
    parameter int DIV = 12
) (
    input  wire logic  clk_in,
    input  wire logic  rstn_in,
    input  wire logic  run_in,
    input  wire logic  prescale_off_in,
    rct_tick_if.src    tick_if
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run_in) begin
            cnt_d = 4'h0;
        end else if (!prescale_off_in) begin
            tick_d = 1'b1;
        end else if (cnt_q == 4'(DIV - 1)) begin
            cnt_d  = 4'h0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q  <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_if.tick = tick_q;
endmodule : rct_prescaler

// ==== core/rct_timer.sv ====
// Top of the 16-bit reload/capture timer
// Contract
// RL1: The timer holds a 16-bit count and offers exactly an auto-reload mode and a capture mode.
// RL2: With the prescaler disabled the count advances once every twelve clock cycles.
// RL3: The count runs continuously while enabled and never stops on overflow or reload.
// RL4: Up-only reload mode counts up from the reload value and overflows after FFFF.
// RL5: Up-only reload mode reloads on overflow alone or also on a chosen edge of the control input.
// RL6: A reload loads the count from the reload/capture register.
// RL7: Every reload in up-only reload mode raises the interrupt request.
// RL8: With up/down enabled the control input level picks count up or count down.
// RL9: With up/down enabled no reload interrupt is raised and counting up reloads on overflow only.
// RL10: Counting down reaches the reload value, underflows and restarts from FFFF.
// RL11: Capture mode counts up from 0000 and reloads 0000 on overflow.
// RL12: In capture mode the chosen edge of the control input copies the count into the capture register.
// RL13: In capture mode overflow and capture both raise the interrupt request.
// RL14: The control input is synchronised by two flip-flops before use.
// RL15: Event flags stay set until cleared by software and drive the request while enabled.
`timescale 1ns/100ps
`include "rct_defines.svh"
module rct_timer import rct_pkg::*; #(
    parameter int COUNT_W = 16,
    parameter int DIV     = 12
) (
    input  wire logic               clk_in,
    input  wire logic               rstn_in,
    input  wire logic               run_in,
    input  wire logic               prescale_off_in,
    input  wire logic               capture_mode_in,
    input  wire logic               updown_en_in,
    input  wire logic               ext_reload_en_in,
    input  wire logic               edge_rise_in,
    input  wire logic               reload_wr_in,
    input  wire logic [COUNT_W-1:0] reload_wdata_in,
    input  wire logic               external_control_input_in,
    input  wire logic               flag_reload_clr_in,
    input  wire logic               flag_capture_clr_in,
    input  wire logic               irq_en_in,
    output logic [COUNT_W-1:0]      timer_count_value_out,
    output logic [COUNT_W-1:0]      reload_capture_value_out,
    output logic                    flag_reload_out,
    output logic                    flag_capture_out,
    output logic                    count_down_out,
    output logic                    irq_out
);
    localparam logic [COUNT_W-1:0] TOP  = COUNT_W'(`RCT_TOP_VALUE);
    localparam logic [COUNT_W-1:0] ZERO = COUNT_W'(`RCT_CAP_RELOAD);

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    rct_tick_if tick_bus ();

    rct_prescaler #(
        .DIV (DIV)
    ) u_prescaler (
        .clk_in          (clk_in),
        .rstn_in         (rstn_in),
        .run_in          (run_in),
        .prescale_off_in (prescale_off_in),
        .tick_if         (tick_bus.src)
    ); // RL2

    // ----------------------------------------------------------------
    // Control input synchroniser and edge detect
    // ----------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic sync1_d;
    logic sync2_d;
    logic prev_d;

    always_comb begin
        sync1_d = external_control_input_in;
        sync2_d = sync1_q; // RL14
        prev_d  = sync2_q;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // Edges are held off until the chain holds real pin samples, so the reset
    // level of the flops cannot pose as an edge of an idle-high pin
    logic [2:0] prime_q;
    logic [2:0] prime_d;

    always_comb begin
        prime_d = {prime_q[1:0], 1'b1};
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prime_q <= 3'h0;
        end else begin
            prime_q <= prime_d;
        end
    end

    // Edges are taken on the clock, not the tick, so a short pulse is not missed
    logic rise_seen;
    logic fall_seen;
    logic edge_hit;

    always_comb begin
        rise_seen = sync2_q & ~prev_q;
        fall_seen = ~sync2_q & prev_q;
        edge_hit  = prime_q[2] & (edge_rise_in ? rise_seen : fall_seen); // RL14
    end

    // ----------------------------------------------------------------
    // Mode and direction decode
    // ----------------------------------------------------------------
    rct_mode_t          mode;
    logic               down;
    logic               up_only;
    logic               up_down;

    assign mode    = capture_mode_in ? RCT_MODE_CAPTURE : RCT_MODE_RELOAD; // RL1
    assign up_only = (mode == RCT_MODE_RELOAD) && !updown_en_in;
    assign up_down = (mode == RCT_MODE_RELOAD) && updown_en_in;
    // Direction follows the synchronised level, never the raw pin
    assign down    = up_down && !sync2_q; // RL8

    // ----------------------------------------------------------------
    // Count boundaries
    // ----------------------------------------------------------------
    logic [COUNT_W-1:0] cnt_q;
    logic [COUNT_W-1:0] rc_q;
    logic               at_top;
    logic               at_floor;
    logic [COUNT_W-1:0] cnt_inc;
    logic [COUNT_W-1:0] cnt_dec;

    always_comb begin
        at_top   = (cnt_q == TOP);
        // Down counting wraps at the reload value, not at zero
        at_floor = (cnt_q == rc_q);
        cnt_inc  = cnt_q + 1'b1;
        cnt_dec  = cnt_q - 1'b1;
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic [COUNT_W-1:0] cnt_d;
    logic               reload_ev;
    logic               reload_irq;

    always_comb begin
        cnt_d      = cnt_q;
        reload_ev  = 1'b0;
        reload_irq = 1'b0;
        case (mode)
            RCT_MODE_RELOAD: begin
                if (up_only) begin
                    // Edge reload applies even between ticks
                    if (run_in && ext_reload_en_in && edge_hit) begin // RL5
                        cnt_d     = rc_q; // RL6
                        reload_ev = 1'b1;
                    end else if (tick_bus.tick) begin // RL3
                        if (at_top) begin // RL4
                            cnt_d     = rc_q; // RL6
                            reload_ev = 1'b1;
                        end else begin
                            cnt_d = cnt_inc;
                        end
                    end
                    reload_irq = reload_ev; // RL7
                end else if (tick_bus.tick) begin
                    // Up/down reloads stay silent: no event reaches the flags
                    if (!down) begin
                        cnt_d = at_top ? rc_q : cnt_inc; // RL9
                    end else begin
                        cnt_d = at_floor ? TOP : cnt_dec; // RL10
                    end
                end
            end
            RCT_MODE_CAPTURE: begin
                if (tick_bus.tick) begin
                    if (at_top) begin
                        cnt_d      = ZERO; // RL11
                        reload_irq = 1'b1; // RL13
                    end else begin
                        cnt_d = cnt_inc;
                    end
                end
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= COUNT_W'(`RCT_RESET_VALUE);
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Reload/capture register
    // ----------------------------------------------------------------
    logic [COUNT_W-1:0] rc_d;
    logic               capture_ev;

    always_comb begin
        rc_d       = rc_q;
        capture_ev = 1'b0;
        if (reload_wr_in) begin
            rc_d = reload_wdata_in;
        end
        // A capture beats a write in the same cycle, so no edge is lost
        if ((mode == RCT_MODE_CAPTURE) && run_in && edge_hit) begin
            rc_d       = cnt_q; // RL12
            capture_ev = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rc_q <= COUNT_W'(`RCT_RESET_VALUE);
        end else begin
            rc_q <= rc_d;
        end
    end

    // ----------------------------------------------------------------
    // Reload event flag
    // ----------------------------------------------------------------
    logic frl_q;
    logic frl_d;

    always_comb begin
        // Hardware set wins over a simultaneous software clear
        frl_d = reload_irq | (frl_q & ~flag_reload_clr_in); // RL15
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frl_q <= 1'b0;
        end else begin
            frl_q <= frl_d;
        end
    end

    // ----------------------------------------------------------------
    // Capture event flag
    // ----------------------------------------------------------------
    logic fcap_q;
    logic fcap_d;

    always_comb begin
        // Same priority as the reload flag: the event is never dropped
        fcap_d = capture_ev | (fcap_q & ~flag_capture_clr_in); // RL13
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fcap_q <= 1'b0;
        end else begin
            fcap_q <= fcap_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The request is only a mask of registered flags, so it cannot glitch on
    // counter activity
    assign timer_count_value_out    = cnt_q;
    assign reload_capture_value_out = rc_q;
    assign flag_reload_out          = frl_q;
    assign flag_capture_out         = fcap_q;
    assign count_down_out           = down;
    assign irq_out                  = irq_en_in & (frl_q | fcap_q); // RL15
endmodule : rct_timer

// ==== testbench/rct_pin_model.sv ====
// Model of the source that drives the external control pin
`timescale 1ns/100ps
module rct_pin_model (
    input  wire logic clk_in,
    input  wire logic level_in,
    output logic      pin_out = 1'b1
);
    // Lands after the edge, unrelated to the sampling instant
    always @(posedge clk_in) pin_out <= #3 level_in;
endmodule : rct_pin_model

// ==== testbench/rct_timer_checker.sv ====
// Port assertions for the reload/capture timer
`timescale 1ns/100ps
module rct_timer_checker #(parameter int COUNT_W = 16) (
    input wire logic               clk_in,
    input wire logic               rstn_in,
    input wire logic               run_in,
    input wire logic               prescale_off_in,
    input wire logic               capture_mode_in,
    input wire logic               updown_en_in,
    input wire logic               reload_wr_in,
    input wire logic               flag_reload_clr_in,
    input wire logic               flag_capture_clr_in,
    input wire logic               irq_en_in,
    input wire logic               flag_reload_out,
    input wire logic               flag_capture_out,
    input wire logic               count_down_out,
    input wire logic               irq_out,
    input wire logic [COUNT_W-1:0] timer_count_value_out,
    input wire logic [COUNT_W-1:0] reload_capture_value_out
);
    wire logic [15:0] cnt = timer_count_value_out;
    wire logic [15:0] rcv = reload_capture_value_out;
    // Wrap checks assume one tick per clock, so only undivided running counts
    wire logic        fast = run_in && !prescale_off_in;
    wire logic        rl = fast && !capture_mode_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_irq; irq_out == (irq_en_in && (flag_reload_out || flag_capture_out)); endproperty
    a_irq: assert property (p_irq) else $error("irq differs from enabled flags");
    property p_run; fast [*3] |=> $changed(cnt); endproperty
    a_run: assert property (p_run) else $error("count stopped while running");
    property p_kr; flag_reload_out && !flag_reload_clr_in |=> flag_reload_out; endproperty
    a_kr: assert property (p_kr) else $error("reload flag lost");
    property p_kc; flag_capture_out && !flag_capture_clr_in |=> flag_capture_out; endproperty
    a_kc: assert property (p_kc) else $error("capture flag lost");
    property p_udq; !capture_mode_in && updown_en_in && !flag_reload_out |=> !flag_reload_out; endproperty
    a_udq: assert property (p_udq) else $error("flag raised in up/down");
    property p_cap; capture_mode_in && !$past(reload_wr_in) && $changed(rcv) |-> flag_capture_out; endproperty
    a_cap: assert property (p_cap) else $error("capture without flag");
    property p_cwrap; fast && capture_mode_in && cnt == 16'hffff |-> ##[1:2] (cnt == 16'h0000 && flag_reload_out);
    endproperty
    a_cwrap: assert property (p_cwrap) else $error("capture overflow wrong");
    property p_uwrap; rl && !updown_en_in && cnt == 16'hffff |-> ##[1:2] (cnt == rcv && flag_reload_out); endproperty
    a_uwrap: assert property (p_uwrap) else $error("up overflow wrong");
    property p_under; rl && updown_en_in && count_down_out && cnt == rcv && cnt != 16'hffff |-> ##[1:2] cnt == 16'hffff;
    endproperty
    a_under: assert property (p_under) else $error("underflow reload wrong");
    property p_up1; fast [*3] ##0 (!capture_mode_in && updown_en_in && !count_down_out && cnt != 16'hffff)
        |=> cnt == $past(cnt) + 16'h0001; endproperty
    a_up1: assert property (p_up1) else $error("up step wrong");
    c_cap: cover property (flag_capture_out);
    c_under: cover property (rl && updown_en_in && count_down_out && cnt == 16'hffff);
    c_wrap: cover property (capture_mode_in && cnt == 16'h0000 && flag_reload_out);
endmodule : rct_timer_checker

// ==== testbench/rct_timer_bench.sv ====
// Self-checking bench for the reload/capture timer
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module rct_timer_bench;
    logic        clk_in = 0, rstn_in = 0, run = 0, pre_off = 0, cap = 0, ud = 0, ext = 0, rise = 0;
    logic        wr = 0, clr_r = 0, clr_c = 0, irq_en = 1, lvl = 1, pin, dn, fr, fc, irq;
    logic [15:0] wd = 16'h0000, cnt, rc;
    int          fails = 0, num_checks = 0, n;
    rct_pin_model u_pin (.clk_in, .level_in(lvl), .pin_out(pin));
    rct_timer u_dut (.clk_in, .rstn_in, .run_in(run), .prescale_off_in(pre_off), .capture_mode_in(cap),
        .updown_en_in(ud), .ext_reload_en_in(ext), .edge_rise_in(rise), .reload_wr_in(wr), .reload_wdata_in(wd),
        .external_control_input_in(pin), .flag_reload_clr_in(clr_r), .flag_capture_clr_in(clr_c),
        .irq_en_in(irq_en), .timer_count_value_out(cnt), .reload_capture_value_out(rc),
        .flag_reload_out(fr), .flag_capture_out(fc), .count_down_out(dn), .irq_out(irq));
    initial forever #4 clk_in = ~clk_in;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : step
    task automatic wait_val(input logic [15:0] v, input int lim);
        n = 0;
        while (cnt !== v && n < lim) begin
            step(1);
            n++;
        end
        if (n >= lim) begin
            fails++;
            end_of_test();
        end
    endtask : wait_val
    // Mode bits are {prescale_off, capture, updown, ext_reload, rise}; run is dropped while reconfiguring
    task automatic cfg(input logic [4:0] m, input logic [15:0] v);
        @(posedge clk_in);
        {run, wr, clr_r, clr_c} <= 4'hf - 4'h8;
        {pre_off, cap, ud, ext, rise} <= m;
        wd <= v;
        @(posedge clk_in);
        {run, wr, clr_r, clr_c} <= 4'h8;
        #1;
    endtask : cfg
    task automatic t_div12;
        cfg(5'b10000, 16'h0000);
        wait_val(16'h0002, 40);
        n = 0;
        while (cnt === 16'h0002 && n < 20) begin
            step(1);
            n++;
        end
        `CHK("tick spacing", 12, n)
        $display("div12 done");
    endtask : t_div12
    task automatic t_updown;
        lvl = 0;
        cfg(5'b00100, 16'hfff0);
        wait_val(16'hfff0, 60);
        step(1);
        `CHK("underflow", 16'hffff, cnt)
        `CHK("down", 1'b1, dn)
        lvl = 1;
        step(6);
        wait_val(16'hffff, 40);
        step(1);
        `CHK("ud overflow", 16'hfff0, cnt)
        `CHK("ud flag", 1'b0, fr)
        $display("updown done");
    endtask : t_updown
    task automatic t_uponly;
        cfg(5'b00011, 16'hfff0);
        wait_val(16'hffff, 40);
        step(1);
        `CHK("up reload", 16'hfff0, cnt)
        `CHK("reload flag", 1'b1, fr)
        `CHK("irq", 1'b1, irq)
        @(posedge clk_in);
        irq_en <= 0;
        step(0);
        `CHK("irq masked", 1'b0, irq)
        @(posedge clk_in);
        irq_en <= 1;
        cfg(5'b00011, 16'h8000);
        wait_val(16'h8010, 60);
        lvl = 0;
        @(posedge clk_in);
        clr_r <= 1;
        @(posedge clk_in);
        clr_r <= 0;
        step(8);
        `CHK("wrong edge", 16'h801a, cnt)
        `CHK("flag cleared", 1'b0, fr)
        lvl = 1;
        step(8);
        `CHK("edge reload", 1'b1, cnt - 16'h8000 < 16'h0008)
        `CHK("edge flag", 1'b1, fr)
        $display("uponly done");
    endtask : t_uponly
    task automatic t_capture;
        cfg(5'b01000, 16'h0000);
        step(4);
        lvl = 0;
        step(8);
        `CHK("cap flag", 1'b1, fc)
        `CHK("captured", 1'b1, cnt - rc < 16'h0008)
        wait_val(16'hffff, 70000);
        step(1);
        `CHK("cap wrap", 16'h0000, cnt)
        `CHK("wrap flag", 1'b1, fr)
        $display("capture done");
    endtask : t_capture
    initial begin
        repeat (4) @(posedge clk_in);
        rstn_in <= 1;
        t_div12();
        t_updown();
        t_uponly();
        t_capture();
        end_of_test();
    end
endmodule : rct_timer_bench
bind rct_timer rct_timer_checker #(.COUNT_W(COUNT_W)) u_chk (.clk_in, .rstn_in, .run_in, .prescale_off_in,
    .capture_mode_in, .updown_en_in, .reload_wr_in, .flag_reload_clr_in, .flag_capture_clr_in, .irq_en_in,
    .flag_reload_out, .flag_capture_out, .count_down_out, .irq_out, .timer_count_value_out,
    .reload_capture_value_out);
